//--- include/lcdp_pkg.sv
// shared constants for the character display nibble command port
package lcdp_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // times as printed, in ns
  localparam int T_INIT_NS  = 30_000_000;  // 30 ms
  localparam int T_LONG_NS  = 1_530_000;   // 1.53 ms
  localparam int T_SHORT_NS = 39_000;      // 39 us
  localparam int T_DATA_NS  = 43_000;      // 43 us

  // least times, rounded up to whole cycles
  localparam int INIT_CYC  = (T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LONG_CYC  = (T_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_CYC = (T_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_CYC  = (T_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // host strobe phase length, each of high and low
  localparam int STROBE_CYC = 4;

  localparam int CNT_W = 22;

  // display buffer layout, 40 columns by 2 lines
  localparam logic [6:0] LINE1_FIRST  = 7'h00;
  localparam logic [6:0] LINE1_LAST   = 7'h27;
  localparam logic [6:0] LINE2_FIRST  = 7'h40;
  localparam logic [6:0] LINE2_LAST   = 7'h67;
  localparam logic [5:0] SHIFT_LAST   = 6'h27;
  localparam logic [6:0] CLEAR_LAST   = 7'h7F;
  localparam logic [7:0] BLANK_CHAR   = 8'h20;
  localparam logic [7:0] GLYPH_BLANK  = 8'h00;

  // instruction class bit positions, highest set bit wins
  localparam int OP_DD_ADDR = 7;
  localparam int OP_CG_ADDR = 6;
  localparam int OP_FUNC    = 5;
  localparam int OP_SHIFT   = 4;
  localparam int OP_DISPLAY = 3;
  localparam int OP_ENTRY   = 2;
  localparam int OP_HOME    = 1;
  localparam int OP_CLEAR   = 0;

  // reset values of the mode flags
  localparam logic RST_INCREMENT = 1'b1;
  localparam logic RST_SHIFT_ACC = 1'b0;

  // startup sequence sent by the host
  localparam logic [7:0] BOOT_FUNC_SET  = 8'h28;
  localparam logic [7:0] BOOT_DISP_CTRL = 8'h0C;
  localparam logic [7:0] BOOT_CLEAR     = 8'h01;
  localparam logic [1:0] BOOT_STEPS     = 2'd3;

endpackage

//--- include/lcdp_if.sv
// six-line link between host board and display
interface lcdp_if;
  logic [3:0] nibble;
  logic       register_select;
  logic       nibble_strobe;

  modport host (
    output nibble,
    output register_select,
    output nibble_strobe
  );

  modport dev (
    input nibble,
    input register_select,
    input nibble_strobe
  );
endinterface

//--- src/lcdp_sync.sv
// two-flop synchroniser for pin inputs
module lcdp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

//--- src/lcdp_device.sv
// display end: nibble capture, instruction decode, display and glyph RAM
module lcdp_device
  import lcdp_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int LONG_CYCLES = LONG_CYC,
  parameter int DATA_CYCLES = DATA_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  lcdp_if.dev             LINK,
  input  wire logic [6:0] RD_ADDR,
  input  wire logic [5:0] GLYPH_RD_ADDR,
  output logic      [7:0] RD_DATA,
  output logic      [7:0] GLYPH_DATA,
  output logic            BUSY,
  output logic      [6:0] CURSOR_ADDR,
  output logic      [5:0] DISPLAY_OFFSET,
  output logic            DISPLAY_ON,
  output logic            CURSOR_ON,
  output logic            BLINK_ON,
  output logic            INCREMENT,
  output logic            SHIFT_ON_ACCESS,
  output logic      [3:0] FUNC_CFG
);

  typedef enum logic [2:0] {
    DV_CLEAR  = 3'b001,
    DV_SETTLE = 3'b010,
    DV_IDLE   = 3'b100
  } lcdp_dev_state_t;

  typedef struct packed {
    lcdp_dev_state_t   state;
    logic [6:0]        clr_addr;
    logic              clr_glyph;
    logic [CNT_W-1:0]  wait_cnt;
    logic              busy;
    logic              half;
    logic [3:0]        hi_nib;
    logic              strobe_prev;
    logic [6:0]        dd_addr;
    logic [5:0]        cg_addr;
    logic              target_cg;
    logic              incr;
    logic              shift_acc;
    logic              disp_on;
    logic              cur_on;
    logic              blink_on;
    logic [5:0]        shift_ofs;
    logic [3:0]        func_cfg;
  } lcdp_dev_t;

  lcdp_dev_t st;
  lcdp_dev_t next_st;

  logic [5:0] pins;
  logic [3:0] pin_nib;
  logic       pin_rs;
  logic       pin_strobe;
  logic       strobe_fall;
  logic [7:0] cmd;

  logic       dd_we;
  logic [6:0] dd_wa;
  logic [7:0] dd_wd;
  logic       cg_we;
  logic [5:0] cg_wa;
  logic [7:0] cg_wd;

  logic [7:0] dd_ram [0:127];
  logic [7:0] cg_ram [0:63];

  lcdp_sync #(.W(6)) u_pin_sync (
    .clk (CLK),
    .rst (RST),
    .d   ({LINK.nibble_strobe, LINK.register_select, LINK.nibble}),
    .q   (pins)
  );

  assign pin_nib     = pins[3:0];
  assign pin_rs      = pins[4];
  assign pin_strobe  = pins[5];
  assign strobe_fall = st.strobe_prev & ~pin_strobe;
  assign cmd         = {st.hi_nib, pin_nib};

  // display address step, wrapping across the two 40-column lines
  function automatic logic [6:0] step_dd(input logic [6:0] a,
                                         input logic       up);
    logic [6:0] r;
    r = a;
    if (up) begin
      if (a == LINE1_LAST)      r = LINE2_FIRST;
      else if (a == LINE2_LAST) r = LINE1_FIRST;
      else                      r = a + 7'h01;
    end else begin
      if (a == LINE1_FIRST)      r = LINE2_LAST;
      else if (a == LINE2_FIRST) r = LINE1_LAST;
      else                       r = a - 7'h01;
    end
    return r;
  endfunction

  function automatic logic [5:0] step_ofs(input logic [5:0] o,
                                          input logic       up);
    logic [5:0] r;
    r = o;
    if (up) r = (o == SHIFT_LAST) ? 6'h00 : o + 6'h01;
    else    r = (o == 6'h00) ? SHIFT_LAST : o - 6'h01;
    return r;
  endfunction

  function automatic logic addr_valid(input logic [6:0] a);
    return (a <= LINE1_LAST) ||
           ((a >= LINE2_FIRST) && (a <= LINE2_LAST));
  endfunction

  always_comb begin
    next_st = st;
    dd_we   = 1'b0;
    dd_wa   = st.dd_addr;
    dd_wd   = cmd;
    cg_we   = 1'b0;
    cg_wa   = st.cg_addr;
    cg_wd   = cmd;
    next_st.strobe_prev = pin_strobe;
    if (st.wait_cnt != '0) begin
      next_st.wait_cnt = st.wait_cnt - CNT_W'(1);
    end
    unique case (st.state)
      DV_CLEAR: begin
        // sweep every address; glyph RAM only at power-up
        dd_we = 1'b1;
        dd_wa = st.clr_addr;
        dd_wd = BLANK_CHAR;
        cg_we = st.clr_glyph;
        cg_wa = st.clr_addr[5:0];
        cg_wd = GLYPH_BLANK;
        next_st.clr_addr = st.clr_addr + 7'h01;
        if (st.clr_addr == CLEAR_LAST) begin
          next_st.state = DV_SETTLE;
        end
      end
      DV_SETTLE: begin
        if (next_st.wait_cnt == '0) begin
          next_st.state = DV_IDLE;
        end
      end
      DV_IDLE: begin
        if (strobe_fall && !st.half) begin
          next_st.hi_nib = pin_nib;
          next_st.half   = 1'b1;
        end else if (strobe_fall) begin
          next_st.half = 1'b0;
          if (pin_rs) begin
            next_st.wait_cnt = CNT_W'(DATA_CYCLES);
            if (st.target_cg) begin
              cg_we = 1'b1;
              next_st.cg_addr = st.incr ? st.cg_addr + 6'h01
                                        : st.cg_addr - 6'h01;
            end else begin
              dd_we = 1'b1;
              next_st.dd_addr = step_dd(st.dd_addr, st.incr);
              if (st.shift_acc) begin
                next_st.shift_ofs = step_ofs(st.shift_ofs, st.incr);
              end
            end
          end else begin
            next_st.wait_cnt = CNT_W'(SHORT_CYC);
            if (cmd[OP_DD_ADDR]) begin
              // out-of-range addresses are ignored
              if (addr_valid(cmd[6:0])) begin
                next_st.dd_addr = cmd[6:0];
              end
              next_st.target_cg = 1'b0;
            end else if (cmd[OP_CG_ADDR]) begin
              next_st.cg_addr   = cmd[5:0];
              next_st.target_cg = 1'b1;
            end else if (cmd[OP_FUNC]) begin
              next_st.func_cfg = cmd[3:0];
            end else if (cmd[OP_SHIFT]) begin
              // shift right moves the window origin left
              if (cmd[3]) begin
                next_st.shift_ofs = step_ofs(st.shift_ofs, !cmd[2]);
              end else begin
                next_st.dd_addr = step_dd(st.dd_addr, cmd[2]);
              end
            end else if (cmd[OP_DISPLAY]) begin
              next_st.disp_on  = cmd[2];
              next_st.cur_on   = cmd[1];
              next_st.blink_on = cmd[0];
            end else if (cmd[OP_ENTRY]) begin
              next_st.incr      = cmd[1];
              next_st.shift_acc = cmd[0];
            end else if (cmd[OP_HOME]) begin
              next_st.dd_addr   = LINE1_FIRST;
              next_st.shift_ofs = 6'h00;
              next_st.target_cg = 1'b0;
              next_st.wait_cnt  = CNT_W'(LONG_CYCLES);
            end else if (cmd[OP_CLEAR]) begin
              next_st.dd_addr   = LINE1_FIRST;
              next_st.shift_ofs = 6'h00;
              next_st.target_cg = 1'b0;
              next_st.incr      = 1'b1;
              next_st.clr_addr  = 7'h00;
              next_st.clr_glyph = 1'b0;
              next_st.state     = DV_CLEAR;
              next_st.wait_cnt  = CNT_W'(LONG_CYCLES);
            end
          end
        end
      end
    endcase
    if (next_st.state != DV_IDLE) begin
      next_st.half = 1'b0;
    end
    next_st.busy = (next_st.wait_cnt != '0) || (next_st.state != DV_IDLE);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st           <= '0;
      st.state     <= DV_CLEAR;
      st.clr_glyph <= 1'b1;
      st.wait_cnt  <= CNT_W'(INIT_CYCLES);
      st.busy      <= 1'b1;
      st.incr      <= RST_INCREMENT;
      st.shift_acc <= RST_SHIFT_ACC;
    end else begin
      st <= next_st;
    end
  end

  // RAM holds no reset; power-up sweep fills it
  always_ff @(posedge CLK) begin
    if (dd_we) dd_ram[dd_wa] <= dd_wd;
    if (cg_we) cg_ram[cg_wa] <= cg_wd;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      RD_DATA    <= 8'h00;
      GLYPH_DATA <= 8'h00;
    end else begin
      RD_DATA    <= dd_ram[RD_ADDR];
      GLYPH_DATA <= cg_ram[GLYPH_RD_ADDR];
    end
  end

  assign BUSY            = st.busy;
  assign CURSOR_ADDR     = st.dd_addr;
  assign DISPLAY_OFFSET  = st.shift_ofs;
  assign DISPLAY_ON      = st.disp_on;
  assign CURSOR_ON       = st.cur_on;
  assign BLINK_ON        = st.blink_on;
  assign INCREMENT       = st.incr;
  assign SHIFT_ON_ACCESS = st.shift_acc;
  assign FUNC_CFG        = st.func_cfg;

endmodule

//--- src/lcdp_host.sv
// host end: power-up wait, startup sequence, nibble sender with pacing
module lcdp_host
  import lcdp_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int LONG_CYCLES = LONG_CYC,
  parameter int DATA_CYCLES = DATA_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  lcdp_if.host            LINK,
  input  wire logic       CMD_VALID,
  input  wire logic       CMD_RS,
  input  wire logic [7:0] CMD_BYTE,
  output logic            CMD_READY
);

  typedef enum logic [3:0] {
    HS_POWER = 4'b0001,
    HS_IDLE  = 4'b0010,
    HS_SEND  = 4'b0100,
    HS_EXEC  = 4'b1000
  } lcdp_host_state_t;

  typedef struct packed {
    lcdp_host_state_t  state;
    logic [CNT_W-1:0]  cnt;
    logic [1:0]        phase;
    logic [1:0]        boot;
    logic [7:0]        byte_q;
    logic              rs;
    logic [3:0]        nib;
    logic              strobe;
    logic              ready;
  } lcdp_host_t;

  lcdp_host_t st;
  lcdp_host_t next_st;
  logic [7:0] boot_byte;

  always_comb begin
    unique case (st.boot)
      2'd0:    boot_byte = BOOT_FUNC_SET;
      2'd1:    boot_byte = BOOT_DISP_CTRL;
      default: boot_byte = BOOT_CLEAR;
    endcase
  end

  always_comb begin
    next_st = st;
    if (st.cnt != '0) begin
      next_st.cnt = st.cnt - CNT_W'(1);
    end
    unique case (st.state)
      HS_POWER: begin
        if (st.cnt == '0) next_st.state = HS_IDLE;
      end
      HS_IDLE: begin
        // startup bytes go out before any user command
        if (st.boot != BOOT_STEPS || CMD_VALID) begin
          next_st.byte_q = (st.boot != BOOT_STEPS) ? boot_byte : CMD_BYTE;
          next_st.rs     = (st.boot != BOOT_STEPS) ? 1'b0 : CMD_RS;
          next_st.nib    = next_st.byte_q[7:4];
          next_st.strobe = 1'b1;
          next_st.phase  = 2'd0;
          next_st.cnt    = CNT_W'(STROBE_CYC - 1);
          next_st.state  = HS_SEND;
          if (st.boot != BOOT_STEPS) next_st.boot = st.boot + 2'd1;
        end
      end
      HS_SEND: begin
        if (st.cnt == '0) begin
          next_st.phase = st.phase + 2'd1;
          next_st.cnt   = CNT_W'(STROBE_CYC - 1);
          unique case (st.phase)
            2'd0: next_st.strobe = 1'b0;
            2'd1: begin
              next_st.nib    = st.byte_q[3:0];
              next_st.strobe = 1'b1;
            end
            2'd2: next_st.strobe = 1'b0;
            2'd3: begin
              next_st.state = HS_EXEC;
              if (st.rs)                   next_st.cnt = CNT_W'(DATA_CYCLES);
              else if (st.byte_q[7:2] == 6'h00)
                                           next_st.cnt = CNT_W'(LONG_CYCLES);
              else                         next_st.cnt = CNT_W'(SHORT_CYC);
            end
          endcase
        end
      end
      HS_EXEC: begin
        if (st.cnt == '0) next_st.state = HS_IDLE;
      end
    endcase
    next_st.ready = (next_st.state == HS_IDLE) && (next_st.boot == BOOT_STEPS)
                    && !(st.state == HS_IDLE && CMD_VALID && st.ready);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st       <= '0;
      st.state <= HS_POWER;
      st.cnt   <= CNT_W'(INIT_CYCLES);
    end else begin
      st <= next_st;
    end
  end

  assign LINK.nibble          = st.nib;
  assign LINK.register_select = st.rs;
  assign LINK.nibble_strobe   = st.strobe;
  assign CMD_READY            = st.ready;

endmodule

//--- bench/lcdp_assertions.sv
// link timing and framing checks between host and display ends
module lcdp_assertions
  import lcdp_pkg::*;
#(
  parameter int INIT_CYCLES = 300,
  parameter int LONG_CYCLES = 200,
  parameter int DATA_CYCLES = 50
) (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic [3:0] nibble,
  input wire logic       register_select,
  input wire logic       nibble_strobe,
  input wire logic       BUSY
);
  logic       s_q;
  logic       half;
  logic       first;
  logic [3:0] hi;
  int         age;
  int         gap;
  int         need;
  wire        fall = s_q & ~nibble_strobe;

  always_ff @(posedge CLK) begin
    s_q <= nibble_strobe;
    if (RST) begin
      half  <= 1'b0;
      first <= 1'b1;
      hi    <= 4'h0;
      age   <= 0;
      gap   <= 0;
      need  <= 0;
    end else begin
      age <= age + 1;
      gap <= gap + 1;
      if (fall) begin
        half  <= ~half;
        first <= 1'b0;
        hi    <= nibble;
      end
      // lower nibble closes the byte, the owed wait starts here
      if (fall && half) begin
        gap  <= 0;
        need <= register_select ? DATA_CYCLES
              : ({hi, nibble[3:2]} == 6'h00) ? LONG_CYCLES : SHORT_CYC;
      end
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  chk_init_quiet: assert property (
    $rose(nibble_strobe) |-> age >= INIT_CYCLES - 1)
    else $error("strobe raised before init wait");
  chk_strobe_high: assert property (
    $rose(nibble_strobe) |-> nibble_strobe[*4] ##1 !nibble_strobe)
    else $error("strobe high phase length wrong");
  chk_strobe_low: assert property (
    $fell(nibble_strobe) |-> !nibble_strobe[*4])
    else $error("strobe low phase too short");
  chk_nibble_hold: assert property (
    $past(nibble_strobe) |-> $stable(nibble))
    else $error("nibble changed under strobe");
  chk_select_hold: assert property (
    half |-> $stable(register_select))
    else $error("select changed inside a byte");
  chk_boot_first: assert property (
    fall && first |-> nibble == BOOT_FUNC_SET[7:4] && !register_select)
    else $error("first byte is not function set");
  chk_exec_gap: assert property (
    $rose(nibble_strobe) && !half |-> gap >= need)
    else $error("next byte before execution time");
  chk_upper_idle: assert property (
    fall && !half && !BUSY |=> !BUSY[*6])
    else $error("execution on upper nibble");
  chk_exec_busy: assert property (
    fall && half |-> ##[1:8] BUSY)
    else $error("no execution after lower nibble");
endmodule

//--- bench/tb_top.sv
// self-checking bench: host end drives display end over the link
module tb_top
  import lcdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // shortened waits; the fixed 39 us still dominates the run
  localparam int IC = 300;
  localparam int LC = 200;
  localparam int DC = 50;

  logic       CLK;
  logic       RST;
  logic       CMD_VALID;
  logic       CMD_RS;
  logic       CMD_READY;
  logic       BUSY;
  logic [7:0] CMD_BYTE;
  logic [7:0] RD_DATA;
  logic [7:0] GLYPH_DATA;
  logic [6:0] RD_ADDR;
  logic [6:0] CURSOR_ADDR;
  logic [5:0] GLYPH_RD_ADDR;
  logic [5:0] DISPLAY_OFFSET;
  logic       DISPLAY_ON;
  logic       CURSOR_ON;
  logic       BLINK_ON;
  logic       INCREMENT;
  logic       SHIFT_ON_ACCESS;
  logic [3:0] FUNC_CFG;
  int         n_mismatch;
  int         comparisons;
  logic [6:0] cur;
  logic [5:0] off;
  logic       inc;
  logic       sh;
  logic [7:0] last;
  logic [5:0] g;
  logic [3:0] mon_hi;
  logic [3:0] mon_lo;

  lcdp_if lcdp_if_i ();
  lcdp_host #(.INIT_CYCLES(IC), .LONG_CYCLES(LC), .DATA_CYCLES(DC))
    lcdp_host_i (.CLK(CLK), .RST(RST), .LINK(lcdp_if_i.host),
      .CMD_VALID(CMD_VALID), .CMD_RS(CMD_RS), .CMD_BYTE(CMD_BYTE),
      .CMD_READY(CMD_READY));
  lcdp_device #(.INIT_CYCLES(IC), .LONG_CYCLES(LC), .DATA_CYCLES(DC))
    lcdp_device_i (.CLK(CLK), .RST(RST), .LINK(lcdp_if_i.dev),
      .RD_ADDR(RD_ADDR), .GLYPH_RD_ADDR(GLYPH_RD_ADDR),
      .RD_DATA(RD_DATA), .GLYPH_DATA(GLYPH_DATA), .BUSY(BUSY),
      .CURSOR_ADDR(CURSOR_ADDR), .DISPLAY_OFFSET(DISPLAY_OFFSET),
      .DISPLAY_ON(DISPLAY_ON), .CURSOR_ON(CURSOR_ON),
      .BLINK_ON(BLINK_ON), .INCREMENT(INCREMENT),
      .SHIFT_ON_ACCESS(SHIFT_ON_ACCESS), .FUNC_CFG(FUNC_CFG));
  lcdp_assertions #(.INIT_CYCLES(IC), .LONG_CYCLES(LC), .DATA_CYCLES(DC))
    lcdp_assertions_i (.CLK(CLK), .RST(RST), .nibble(lcdp_if_i.nibble),
      .register_select(lcdp_if_i.register_select),
      .nibble_strobe(lcdp_if_i.nibble_strobe), .BUSY(BUSY));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // nibble is held through the fall, so sampling there is race free
  always @(negedge lcdp_if_i.nibble_strobe) begin
    mon_hi = mon_lo;
    mon_lo = lcdp_if_i.nibble;
  end

  function automatic logic [6:0] step(input logic [6:0] a, input logic up);
    if (up)
      return a == LINE1_LAST ? LINE2_FIRST
           : a == LINE2_LAST ? LINE1_FIRST : a + 7'h01;
    return a == LINE2_FIRST ? LINE1_LAST
         : a == LINE1_FIRST ? LINE2_LAST : a - 7'h01;
  endfunction

  function automatic logic [5:0] shf(input logic [5:0] o, input logic up);
    if (up)
      return o == SHIFT_LAST ? 6'h00 : o + 6'h01;
    return o == 6'h00 ? SHIFT_LAST : o - 6'h01;
  endfunction

  task automatic summarize();
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wait_ready();
    int k;
    for (k = 0; k < 20000 && CMD_READY !== 1'b1; k++)
      @(negedge CLK);
    if (k == 20000) begin
      chk(8'(CMD_READY), 8'h01);
      summarize();
    end
  endtask

  task automatic send(input logic rs, input logic [7:0] b);
    wait_ready();
    CMD_VALID = 1'b1;
    CMD_RS = rs;
    CMD_BYTE = b;
    @(negedge CLK);
    CMD_VALID = 1'b0;
    @(negedge CLK);
    wait_ready();
    chk({mon_hi, mon_lo}, b);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    RD_ADDR = a;
    repeat (2) @(negedge CLK);
    chk(RD_DATA, e);
  endtask

  task automatic put(input logic [7:0] d);
    send(1'b1, d);
    rd(cur, d);
    last = d;
    cur = step(cur, inc);
    if (sh)
      off = shf(off, inc);
    chk(8'(CURSOR_ADDR), 8'(cur));
    chk(8'(DISPLAY_OFFSET), 8'(off));
  endtask

  initial begin
    RST = 1'b1;
    CMD_VALID = 1'b0;
    CMD_RS = 1'b0;
    CMD_BYTE = 8'h00;
    RD_ADDR = 7'h00;
    GLYPH_RD_ADDR = 6'h00;
    n_mismatch = 0;
    comparisons = 0;
    void'($urandom(13518));
    repeat (16) @(negedge CLK);
    chk({6'h00, BUSY, INCREMENT}, 8'h03);
    RST = 1'b0;
    wait_ready();
    chk(8'(FUNC_CFG), 8'(BOOT_FUNC_SET[3:0]));
    chk({5'h00, DISPLAY_ON, CURSOR_ON, BLINK_ON},
        8'(BOOT_DISP_CTRL[2:0]));
    chk(8'(CURSOR_ADDR), 8'h00);
    rd(LINE2_LAST, BLANK_CHAR);
    GLYPH_RD_ADDR = 6'h3F;
    repeat (2) @(negedge CLK);
    chk(GLYPH_DATA, GLYPH_BLANK);
    off = 6'h00;
    inc = 1'b1;
    sh = 1'b0;
    // start one short of the line end to cross into the second line
    cur = LINE1_LAST - 7'h01;
    send(1'b0, {1'b1, cur});
    chk(8'(CURSOR_ADDR), 8'(cur));
    repeat (4) put(8'($urandom));
    send(1'b0, 8'h07);
    sh = 1'b1;
    chk({6'h00, INCREMENT, SHIFT_ON_ACCESS}, 8'h03);
    put(8'($urandom));
    send(1'b0, 8'h1C);
    off = shf(off, 1'b0);
    chk(8'(DISPLAY_OFFSET), 8'(off));
    chk(8'(CURSOR_ADDR), 8'(cur));
    rd(step(cur, 1'b0), last);
    send(1'b0, 8'h04);
    inc = 1'b0;
    sh = 1'b0;
    chk({6'h00, INCREMENT, SHIFT_ON_ACCESS}, 8'h00);
    repeat (3) put(8'($urandom));
    send(1'b0, 8'h02);
    chk({1'h0, CURSOR_ADDR}, 8'h00);
    chk(8'(DISPLAY_OFFSET), 8'h00);
    // last decrementing write went one above the final cursor
    rd(step(cur, 1'b1), last);
    cur = LINE1_FIRST;
    off = 6'h00;
    // right, left, then left again across the 00 to 67 wrap
    for (int i = 0; i < 3; i++) begin
      send(1'b0, i == 0 ? 8'h14 : 8'h10);
      cur = step(cur, i == 0);
      chk(8'(CURSOR_ADDR), 8'(cur));
    end
    send(1'b0, 8'h18);
    off = shf(off, 1'b1);
    chk(8'(DISPLAY_OFFSET), 8'(off));
    g = 6'($urandom);
    last = 8'($urandom);
    send(1'b0, {2'b01, g});
    send(1'b1, last);
    GLYPH_RD_ADDR = g;
    repeat (2) @(negedge CLK);
    chk(GLYPH_DATA, last);
    for (int i = 8; i < 16; i++) begin
      send(1'b0, 8'(i));
      chk({5'h00, DISPLAY_ON, CURSOR_ON, BLINK_ON}, 8'(i & 7));
    end
    send(1'b0, 8'h2B);
    chk(8'(FUNC_CFG), 8'h0B);
    send(1'b0, BOOT_CLEAR);
    chk({CURSOR_ADDR, INCREMENT}, 8'h01);
    chk(8'(DISPLAY_OFFSET), 8'h00);
    rd(LINE2_FIRST, BLANK_CHAR);
    summarize();
  end
endmodule
